// >>> rtl/tpp_map.svh
/*
 * Holds the widths, reset values, select encodings and timing figures of the
 * timer, prescaler and PWM block.
 * Assumes it is included by its bare name before any file that uses it.
 */
`ifndef TPP_MAP_SVH
`define TPP_MAP_SVH

// ----------------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------------
`define TPP_DATA_W 8
`define TPP_PT_W 4

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define TPP_PS_RST 8'hFF
`define TPP_T_RST 8'hFF
`define TPP_PT_RST 4'hF
`define TPP_READ_RST 8'h00

// ----------------------------------------------------------------------------
// select encodings
// ----------------------------------------------------------------------------
`define TPP_T1_SRC_PS 1'b0
`define TPP_T1_SRC_PIN 1'b1
`define TPP_EDGE_RISE 1'b0
`define TPP_EDGE_FALL 1'b1
`define TPP_PT_SRC_PS 1'b0
`define TPP_PT_SRC_T1 1'b1

// ----------------------------------------------------------------------------
// clock figures
// ----------------------------------------------------------------------------
`define TPP_CLK_PERIOD_NS 40
`define TPP_SYNC_STAGES 3

`endif

// >>> rtl/tpp_pkg.sv
/*
 * Holds the types of the timer, prescaler and PWM block: the transfer
 * operation codes and the packed carriers for operations and configuration.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tpp_pkg;

    // ------------------------------------------------------------------------
    // transfer operations
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        TPP_OP_NONE = 4'h0,
        TPP_OP_PRESCALER_READ = 4'h1,
        TPP_OP_PRESCALER_WRITE = 4'h2,
        TPP_OP_TIMER_ONE_READ = 4'h3,
        TPP_OP_TIMER_TWO_READ = 4'h4,
        TPP_OP_TIMER_ONE_WRITE = 4'h5,
        TPP_OP_TIMER_TWO_WRITE = 4'h6,
        TPP_OP_TIMER_TWO_LOW_RELOAD_WRITE = 4'h7,
        TPP_OP_PANEL_TIMER_WRITE = 4'h8,
        TPP_OP_RELOAD_ONE_WRITE = 4'h9,
        TPP_OP_RELOAD_TWO_HIGH_WRITE = 4'hA
    } tpp_op_e;

    // one transfer request, valid for one cycle
    typedef struct packed {
        logic valid;
        tpp_op_e code;
        logic [7:0] data;
    } tpp_op_s;

    // run bits and selects held by software
    typedef struct packed {
        logic ps_run;
        logic t1_run;
        logic t2_run;
        logic pt_run;
        logic t1_src_pin;
        logic pin_fall;
        logic pt_src_t1;
        logic pwm_en;
        logic pwm_expand;
    } tpp_cfg_s;

endpackage

// >>> rtl/tpp_reload_ctr.sv
/*
 * Holds one reloadable down counter with a direct load, a reload value taken
 * at underflow, and a registered one-cycle underflow pulse.
 * Assumes the tick is a one-cycle enable on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module tpp_reload_ctr #(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '1
) (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_run,
    input wire logic i_tick,
    input wire logic i_load,
    input wire logic [W-1:0] i_load_val,
    input wire logic [W-1:0] i_reload,
    output logic [W-1:0] o_count,
    output logic o_uf
);

    logic [W-1:0] cnt_q;
    logic uf_q;
    logic at_zero;

    assign at_zero = (cnt_q == '0);
    assign o_count = cnt_q;
    assign o_uf = uf_q;

    // count down on tick, reload at zero
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q <= RST;
        end else if (i_load) begin
            cnt_q <= i_load_val;
        end else if (i_run && i_tick) begin
            cnt_q <= at_zero ? i_reload : cnt_q - 1'b1;
        end
    end

    // underflow pulse in the reload cycle
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            uf_q <= 1'b0;
        end else begin
            uf_q <= i_run && i_tick && at_zero && !i_load;
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_arst_n);

    property p_reload_at_zero;
        i_run && i_tick && at_zero && !i_load |=> (cnt_q == $past(i_reload)) && uf_q;
    endproperty
    a_reload_at_zero: assert property (p_reload_at_zero) else $error("no reload at underflow");

    property p_wait_for_tick;
        !i_load && !(i_run && i_tick) |=> $stable(cnt_q) && !uf_q;
    endproperty
    a_wait_for_tick: assert property (p_wait_for_tick) else $error("count moved without tick");

    property p_step_down;
        i_run && i_tick && !at_zero && !i_load |=> cnt_q == $past(cnt_q) - 1'b1;
    endproperty
    a_step_down: assert property (p_step_down) else $error("count did not step down");

    c_underflow: cover property (uf_q);

endmodule

`default_nettype wire

// >>> rtl/tpp_timer_block.sv
/*
 * Holds the timer subsystem: prescaler, timer one with counter pin input,
 * timer two with PWM, panel timer, transfer operation decode and port C out.
 * Assumes transfer operations and configuration come from logic on the same
 * clock; the counter pin comes from outside and is synchronised here.
 */
`timescale 1ns/100ps
`default_nettype none
`include "tpp_map.svh"

module tpp_timer_block (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire tpp_pkg::tpp_op_s i_op,
    input wire tpp_pkg::tpp_cfg_s i_cfg,
    input wire logic i_port_c_latch,
    input wire logic i_counter_io_pin,
    output logic [7:0] o_read_data,
    output logic o_read_valid,
    output logic o_ps_uf,
    output logic o_t1_uf,
    output logic o_t2_uf,
    output logic o_pt_uf,
    output logic o_port_c
);

    // ------------------------------------------------------------------------
    // operation decode
    // ------------------------------------------------------------------------
    function automatic logic is_op(input tpp_pkg::tpp_op_s op, input tpp_pkg::tpp_op_e code);
        is_op = op.valid && (op.code == code);
    endfunction

    logic ps_wr, t1_wr, t2_wr, t2l_wr, pt_wr, t1_rl_wr, t2_rl_hi_wr, rd_any;
    assign ps_wr = is_op(i_op, tpp_pkg::TPP_OP_PRESCALER_WRITE);
    assign t1_wr = is_op(i_op, tpp_pkg::TPP_OP_TIMER_ONE_WRITE);
    assign t2_wr = is_op(i_op, tpp_pkg::TPP_OP_TIMER_TWO_WRITE);
    assign t2l_wr = is_op(i_op, tpp_pkg::TPP_OP_TIMER_TWO_LOW_RELOAD_WRITE);
    assign pt_wr = is_op(i_op, tpp_pkg::TPP_OP_PANEL_TIMER_WRITE);
    assign t1_rl_wr = is_op(i_op, tpp_pkg::TPP_OP_RELOAD_ONE_WRITE);
    assign t2_rl_hi_wr = is_op(i_op, tpp_pkg::TPP_OP_RELOAD_TWO_HIGH_WRITE);
    assign rd_any = is_op(i_op, tpp_pkg::TPP_OP_PRESCALER_READ) || is_op(i_op, tpp_pkg::TPP_OP_TIMER_ONE_READ)
        || is_op(i_op, tpp_pkg::TPP_OP_TIMER_TWO_READ);

    // ------------------------------------------------------------------------
    // reload registers
    // ------------------------------------------------------------------------
    logic [7:0] ps_rl_q, t1_rl_q, r2l_q, t2_rl_hi_q;
    logic [3:0] pt_rl_q;

    // reload values written by transfers
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ps_rl_q <= `TPP_PS_RST;
            t1_rl_q <= `TPP_T_RST;
            r2l_q <= `TPP_T_RST;
            t2_rl_hi_q <= `TPP_T_RST;
            pt_rl_q <= `TPP_PT_RST;
        end else begin
            if (ps_wr) ps_rl_q <= i_op.data;
            if (t1_wr || t1_rl_wr) t1_rl_q <= i_op.data;
            if (t2_wr || t2l_wr) r2l_q <= i_op.data;
            if (t2_rl_hi_wr) t2_rl_hi_q <= i_op.data; // software keeps it nonzero
            if (pt_wr) pt_rl_q <= i_op.data[3:0];
        end
    end

    // ------------------------------------------------------------------------
    // counter pin synchroniser
    // ------------------------------------------------------------------------
    logic pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q, pin_prev_q, pin_edge;

    // three stages, level taken once stages two and three agree
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
            pin_lvl_q <= 1'b0;
            pin_prev_q <= 1'b0;
        end else begin
            pin_s1_q <= i_counter_io_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            if (pin_s2_q == pin_s3_q) pin_lvl_q <= pin_s3_q;
            pin_prev_q <= pin_lvl_q;
        end
    end

    // selected edge only
    assign pin_edge = (pin_lvl_q != pin_prev_q) && (pin_lvl_q == (i_cfg.pin_fall == `TPP_EDGE_RISE));

    // ------------------------------------------------------------------------
    // counters
    // ------------------------------------------------------------------------
    logic [7:0] ps_cnt, t1_cnt, t2_cnt, t2_reload;
    logic ps_uf, t1_uf, t2_uf, pt_uf, t1_tick, pt_tick, pwm_hi_q;

    // first tick after start comes at a source edge, so first period may be short
    assign t1_tick = (i_cfg.t1_src_pin == `TPP_T1_SRC_PIN) ? pin_edge : ps_uf;
    assign pt_tick = (i_cfg.pt_src_t1 == `TPP_PT_SRC_T1) ? t1_uf : ps_uf;
    // entering the high phase takes the high reload when expansion is on
    assign t2_reload = (i_cfg.pwm_en && i_cfg.pwm_expand && !pwm_hi_q) ? t2_rl_hi_q : r2l_q;

    tpp_reload_ctr #(.W(8), .RST(`TPP_PS_RST)) u_ps (
        .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_run(i_cfg.ps_run), .i_tick(1'b1),
        .i_load(ps_wr), .i_load_val(i_op.data), .i_reload(ps_rl_q), .o_count(ps_cnt), .o_uf(ps_uf)
    );

    tpp_reload_ctr #(.W(8), .RST(`TPP_T_RST)) u_t1 (
        .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_run(i_cfg.t1_run), .i_tick(t1_tick),
        .i_load(t1_wr), .i_load_val(i_op.data), .i_reload(t1_rl_q), .o_count(t1_cnt), .o_uf(t1_uf)
    );

    tpp_reload_ctr #(.W(8), .RST(`TPP_T_RST)) u_t2 (
        .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_run(i_cfg.t2_run), .i_tick(ps_uf),
        .i_load(t2_wr), .i_load_val(i_op.data), .i_reload(t2_reload), .o_count(t2_cnt), .o_uf(t2_uf)
    );

    tpp_reload_ctr #(.W(`TPP_PT_W), .RST(`TPP_PT_RST)) u_pt (
        .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_run(i_cfg.pt_run), .i_tick(pt_tick),
        .i_load(pt_wr), .i_load_val(i_op.data[3:0]), .i_reload(pt_rl_q), .o_count(), .o_uf(pt_uf)
    );

    assign o_ps_uf = ps_uf;
    assign o_t1_uf = t1_uf;
    assign o_t2_uf = t2_uf;
    assign o_pt_uf = pt_uf;

    // ------------------------------------------------------------------------
    // PWM phase and port C
    // ------------------------------------------------------------------------
    // phase flips on every timer two underflow while PWM is enabled; a stop in that cycle still flips cleanly
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pwm_hi_q <= 1'b0;
        end else if (!i_cfg.pwm_en) begin
            pwm_hi_q <= 1'b0;
        end else if (t2_uf) begin
            pwm_hi_q <= !pwm_hi_q;
        end
    end

    logic port_c_q;
    // latch high always drives high; PWM only while latch is zero
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            port_c_q <= 1'b0;
        end else begin
            port_c_q <= i_port_c_latch || (i_cfg.pwm_en && pwm_hi_q);
        end
    end
    assign o_port_c = port_c_q;

    // ------------------------------------------------------------------------
    // read transfers
    // ------------------------------------------------------------------------
    logic [7:0] rd_q;
    logic rd_v_q;

    // captured count returned one cycle after the request
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rd_q <= `TPP_READ_RST;
            rd_v_q <= 1'b0;
        end else begin
            rd_v_q <= rd_any;
            if (is_op(i_op, tpp_pkg::TPP_OP_PRESCALER_READ)) rd_q <= ps_cnt;
            else if (is_op(i_op, tpp_pkg::TPP_OP_TIMER_ONE_READ)) rd_q <= t1_cnt;
            else if (is_op(i_op, tpp_pkg::TPP_OP_TIMER_TWO_READ)) rd_q <= t2_cnt;
        end
    end
    assign o_read_data = rd_q;
    assign o_read_valid = rd_v_q;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_arst_n);

    property p_port_c_high;
        i_port_c_latch |=> o_port_c;
    endproperty
    a_port_c_high: assert property (p_port_c_high) else $error("port C high lost");

    property p_pwm_route;
        !i_port_c_latch && i_cfg.pwm_en |=> o_port_c == $past(pwm_hi_q);
    endproperty
    a_pwm_route: assert property (p_pwm_route) else $error("PWM not on port C");

    property p_pwm_flip;
        i_cfg.pwm_en && t2_uf |=> pwm_hi_q != $past(pwm_hi_q);
    endproperty
    a_pwm_flip: assert property (p_pwm_flip) else $error("PWM phase did not flip");

    property p_pin_count;
        pin_edge && i_cfg.t1_src_pin && i_cfg.t1_run && !t1_wr && t1_cnt != 8'h00
            |=> t1_cnt == $past(t1_cnt) - 8'h01;
    endproperty
    a_pin_count: assert property (p_pin_count) else $error("timer one missed pin edge");

    // reload and underflow pulse land on the same edge
    property p_high_reload;
        ps_uf && i_cfg.t2_run && t2_cnt == 8'h00 && !t2_wr && i_cfg.pwm_en && i_cfg.pwm_expand && !pwm_hi_q
            |=> t2_cnt == $past(t2_rl_hi_q) && t2_uf;
    endproperty
    a_high_reload: assert property (p_high_reload) else $error("high reload not taken");

    property p_read_ps;
        is_op(i_op, tpp_pkg::TPP_OP_PRESCALER_READ) |=> o_read_valid && o_read_data == $past(ps_cnt);
    endproperty
    a_read_ps: assert property (p_read_ps) else $error("prescaler read wrong");

    property p_ps_period;
        i_cfg.ps_run && !ps_wr && ps_cnt == 8'h00 |=> ps_uf;
    endproperty
    a_ps_period: assert property (p_ps_period) else $error("prescaler underflow missing");

    c_pwm_high: cover property (i_cfg.pwm_en && $rose(pwm_hi_q));
    c_pin_edge: cover property (pin_edge && i_cfg.t1_run);
    c_pt_uf: cover property (pt_uf);

endmodule

`default_nettype wire

// >>> testbench/tpp_timer_block_bench.sv
/*
 * Self-checking bench for the timer, prescaler and PWM block: transfer
 * reads and writes, counter periods, counter pin edges, PWM on port C.
 * Assumes the design files and tpp_map.svh are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none
`include "tpp_map.svh"

module tpp_timer_block_bench;
    logic i_ref_clk;
    logic i_arst_n;
    tpp_pkg::tpp_op_s op;
    tpp_pkg::tpp_cfg_s cfg;
    logic latch;
    logic pin;
    logic [7:0] rd;
    logic rv, ps_uf, t1_uf, t2_uf, pt_uf, port_c;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n, h, l;

    tpp_timer_block tpp_timer_block_i (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_op(op), .i_cfg(cfg),
        .i_port_c_latch(latch), .i_counter_io_pin(pin), .o_read_data(rd), .o_read_valid(rv),
        .o_ps_uf(ps_uf), .o_t1_uf(t1_uf), .o_t2_uf(t2_uf), .o_pt_uf(pt_uf), .o_port_c(port_c));

    // ------------------------------------------------------------------------
    // clock, timeout and closing report
    // ------------------------------------------------------------------------
    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end

    // cut a hang short
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic step();
        @(posedge i_ref_clk);
        #1;
    endtask

    function automatic logic sig(input int k);
        logic [4:0] v;
        v = {port_c, pt_uf, t2_uf, t1_uf, ps_uf};
        return v[k];
    endfunction

    // one transfer, valid for one cycle
    task automatic do_op(input tpp_pkg::tpp_op_e c, input logic [7:0] d);
        step();
        op = '{valid: 1'b1, code: c, data: d};
        step();
        op.valid = 1'b0;
    endtask

    // read, then compare data and the valid pulse
    task automatic rd_chk(input string name, input tpp_pkg::tpp_op_e c, input logic [7:0] exp);
        do_op(c, 8'h00);
        check(name, rd, exp);
        check("read_valid", {7'h00, rv}, 8'h01);
        step();
        check("read_valid_drop", {7'h00, rv}, 8'h00);
    endtask

    // cycles between two pulses of signal k
    task automatic gap(input int k, output int g);
        int i;
        i = 0;
        while (sig(k) !== 1'b1 && i < 600) begin
            step();
            i++;
        end
        step();
        g = 1;
        while (sig(k) !== 1'b1 && g < 600) begin
            step();
            g++;
        end
    endtask

    task automatic count_pulses(input int k, input int len, output int c);
        c = 0;
        repeat (len) begin
            step();
            if (sig(k) === 1'b1) c++;
        end
    endtask

    // one full high run and the low run after it on port C
    task automatic runs(output int hi, output int lo);
        int i;
        i = 0;
        while (port_c !== 1'b0 && i < 200) begin
            step();
            i++;
        end
        while (port_c !== 1'b1 && i < 400) begin
            step();
            i++;
        end
        hi = 0;
        lo = 0;
        while (port_c === 1'b1 && hi < 200) begin
            step();
            hi++;
        end
        while (port_c === 1'b0 && lo < 200) begin
            step();
            lo++;
        end
    endtask

    // ------------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------------
    initial begin
        i_arst_n = 1'b0;
        op = '0;
        cfg = '0;
        latch = 1'b0;
        pin = 1'b0;
        repeat (2) @(posedge i_ref_clk);
        #1;
        check("reset_outputs", {2'b00, rv, ps_uf, t1_uf, t2_uf, pt_uf, port_c}, 8'h00);
        // timer three sits outside this block: its stop and power-down spacing stay with software
        i_arst_n = 1'b1;
        rd_chk("ps_reset", tpp_pkg::TPP_OP_PRESCALER_READ, `TPP_PS_RST);
        rd_chk("t1_reset", tpp_pkg::TPP_OP_TIMER_ONE_READ, `TPP_T_RST);
        rd_chk("t2_reset", tpp_pkg::TPP_OP_TIMER_TWO_READ, `TPP_T_RST);
        $display("test reset and reads done");

        // stopped writes read back
        do_op(tpp_pkg::TPP_OP_PRESCALER_WRITE, 8'h03);
        rd_chk("ps_write", tpp_pkg::TPP_OP_PRESCALER_READ, 8'h03);
        do_op(tpp_pkg::TPP_OP_TIMER_ONE_WRITE, 8'hA5);
        do_op(tpp_pkg::TPP_OP_TIMER_TWO_WRITE, 8'h5A);
        rd_chk("t1_write", tpp_pkg::TPP_OP_TIMER_ONE_READ, 8'hA5);
        rd_chk("t2_write", tpp_pkg::TPP_OP_TIMER_TWO_READ, 8'h5A);
        cfg.ps_run = 1'b1;
        // cycles from start to the first underflow
        n = 0;
        while (ps_uf !== 1'b1 && n < 600) begin
            step();
            n++;
        end
        check("ps_first", {7'h00, n >= 3 && n <= 4}, 8'h01);
        gap(0, n);
        check("ps_period", 8'(n), 8'h04);
        $display("test prescaler done");

        // timer one from prescaler, then reload change while running
        cfg.ps_run = 1'b0;
        do_op(tpp_pkg::TPP_OP_PRESCALER_WRITE, 8'h01);
        do_op(tpp_pkg::TPP_OP_TIMER_ONE_WRITE, 8'h02);
        cfg.ps_run = 1'b1;
        cfg.t1_run = 1'b1;
        gap(1, n);
        gap(1, n);
        check("t1_period", 8'(n), 8'h06);
        do_op(tpp_pkg::TPP_OP_RELOAD_ONE_WRITE, 8'h00);
        gap(1, n);
        gap(1, n);
        check("t1_new_reload", 8'(n), 8'h02);
        $display("test timer one done");

        // timer one on each counter pin edge
        for (int e = 0; e < 2; e++) begin
            cfg = '0;
            cfg.t1_src_pin = `TPP_T1_SRC_PIN;
            cfg.pin_fall = e[0];
            repeat (8) step();
            do_op(tpp_pkg::TPP_OP_TIMER_ONE_WRITE, 8'h01);
            cfg.t1_run = 1'b1;
            // first selected edge steps the count down, the second underflows
            for (int r = 0; r < 2; r++) begin
                pin = 1'b1;
                count_pulses(1, 12, n);
                check("pin_rise", 8'(n), (e == 0 && r == 1) ? 8'h01 : 8'h00);
                pin = 1'b0;
                count_pulses(1, 12, n);
                check("pin_fall", 8'(n), (e == 1 && r == 1) ? 8'h01 : 8'h00);
            end
        end
        $display("test counter pin done");

        // timer two PWM on port C
        cfg = '0;
        do_op(tpp_pkg::TPP_OP_PRESCALER_WRITE, 8'h00);
        do_op(tpp_pkg::TPP_OP_TIMER_TWO_WRITE, 8'h03);
        cfg.ps_run = 1'b1;
        cfg.t2_run = 1'b1;
        cfg.pwm_en = 1'b1;
        runs(h, l);
        check("pwm_high", 8'(h), 8'h04);
        check("pwm_low", 8'(l), 8'h04);
        gap(2, n);
        cfg.t2_run = 1'b0;
        do_op(tpp_pkg::TPP_OP_RELOAD_TWO_HIGH_WRITE, 8'h01);
        do_op(tpp_pkg::TPP_OP_TIMER_TWO_LOW_RELOAD_WRITE, 8'h02);
        cfg.pwm_expand = 1'b1;
        cfg.t2_run = 1'b1;
        runs(h, l);
        check("pwm_exp_high", 8'(h), 8'h02);
        check("pwm_exp_low", 8'(l), 8'h03);
        latch = 1'b1;
        repeat (3) step();
        count_pulses(4, 16, n);
        check("latch_high", 8'(n), 8'h10);
        latch = 1'b0;
        cfg.pwm_en = 1'b0;
        repeat (3) step();
        count_pulses(4, 16, n);
        check("pwm_off", 8'(n), 8'h00);
        $display("test pwm done");

        // panel timer from prescaler, then from timer one
        cfg = '0;
        do_op(tpp_pkg::TPP_OP_PANEL_TIMER_WRITE, 8'h02);
        cfg.ps_run = 1'b1;
        cfg.pt_run = 1'b1;
        gap(3, n);
        gap(3, n);
        check("pt_ps_period", 8'(n), 8'h03);
        cfg.pt_run = 1'b0;
        do_op(tpp_pkg::TPP_OP_TIMER_ONE_WRITE, 8'h01);
        do_op(tpp_pkg::TPP_OP_PANEL_TIMER_WRITE, 8'h01);
        cfg.pt_src_t1 = `TPP_PT_SRC_T1;
        cfg.t1_run = 1'b1;
        cfg.pt_run = 1'b1;
        gap(3, n);
        gap(3, n);
        check("pt_t1_period", 8'(n), 8'h04);
        $display("test panel timer done");
        final_report();
    end
endmodule

`default_nettype wire
